// ==== mux_decode_pkg.sv ====
package mux_decode_pkg;

   // Select code: three fixed top bits, five switch bits.
   localparam logic [2:0] SEL_FIXED_BITS = 3'h3;
   localparam logic [7:0] SEL_BASE_BYTE = 8'h60;
   // Switch pack, position 1 in bit 7 down to position 8 in bit 0.
   localparam logic [7:0] SWITCH_PACK_RESET = 8'h0D;
   localparam int SW_CONSOLE_BIT = 7;
   localparam int SW_LEVEL_HI = 6;
   localparam int SW_LEVEL_LO = 5;
   localparam int SW_CODE_HI = 4;
   localparam logic [3:0] IRQ_LINE_LOWEST = 4'h1;

   // Card-side memory map.
   localparam int CARD_AW = 16;
   localparam int SHARED_AW = 15;
   localparam int PROG_AW = 14;
   localparam logic [15:0] EVENT_REG_ADDR = 16'hC000;
   localparam logic [15:0] CMD_REG_ADDR = 16'hC001;
   localparam logic [15:0] SCRATCH_LO = 16'hC002;
   localparam logic [15:0] RX_FIFO_LO = 16'hC200;
   localparam logic [15:0] BITMAP_LO = 16'hC600;
   localparam logic [15:0] SHARED_CFG_LO = 16'hC700;
   localparam logic [15:0] TX_FIFO_LO = 16'hC76F;
   localparam logic [15:0] TX_FIFO0_HI = 16'hC7AE;
   localparam logic [15:0] STACK_LO = 16'hC7AF;
   localparam logic [15:0] STACK_HI = 16'hC7FF;
   localparam logic [2:0] RX_PORT0_PAGE = 3'h5;
   localparam int RAM_DEPTH_MAX = 8192;
   localparam logic [2:0] RAM_2K_LIMIT = 3'h0;

   // Hardware register space, low address bits.
   localparam logic [1:0] HWREG_RESET_ID = 2'h0;
   localparam logic [1:0] HWREG_IRQ = 2'h1;
   localparam logic [1:0] HWREG_SEMA = 2'h2;
   localparam int CTRL_BIT = 7;
   localparam logic [7:0] OPEN_BUS = 8'hFF;

   // Reset values.
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic SEMA_RESET = 1'b1;

   typedef enum logic [3:0] {
      RGN_PROGRAM, RGN_HWREG, RGN_EVENT, RGN_CMD, RGN_SCRATCH, RGN_RX_FIFO,
      RGN_BITMAP, RGN_SHARED_CFG, RGN_TX_FIFO, RGN_STACK, RGN_UNFITTED
   } region_t;

   typedef struct packed {
      logic [23:0] addr;
      logic write;
      logic [7:0] wdata;
   } host_req_t;

   typedef struct packed {
      logic [15:0] addr;
      logic write;
      logic [7:0] wdata;
   } local_req_t;

endpackage

// ==== host_select_decode.sv ====
`timescale 1ns/1ps
module host_select_decode
   import mux_decode_pkg::*;
(
   input wire logic [7:0] i_addr_hi,
   input wire logic i_backplane_addr_strobe_n,
   input wire logic [7:0] i_switch_pack,
   output logic o_select_match_n,
   output logic [3:0] o_level_sel,
   output logic o_console_remote
);

   logic match;

   always_comb
   begin
      // Comparator is enabled only while the strobe marks a valid address.
      match = !i_backplane_addr_strobe_n
         && (i_addr_hi == {SEL_FIXED_BITS, i_switch_pack[SW_CODE_HI:0]});
      o_select_match_n = !match;
      o_level_sel = IRQ_LINE_LOWEST << i_switch_pack[SW_LEVEL_HI:SW_LEVEL_LO];
      o_console_remote = i_switch_pack[SW_CONSOLE_BIT];
   end

endmodule

// ==== local_space_decode.sv ====
`timescale 1ns/1ps
module local_space_decode
   import mux_decode_pkg::*;
(
   input wire logic [15:0] i_addr,
   input wire logic i_local_mem_request_n,
   input wire logic i_local_refresh_cycle_n,
   input wire logic i_ram_8k_jumper,
   input wire logic i_prog_16k_jumper,
   output logic o_prog_mem_oe,
   output logic [PROG_AW-1:0] o_prog_addr,
   output logic o_local_shared_request,
   output region_t o_region,
   output logic [1:0] o_fifo_port
);

   function automatic logic ram_fitted(input logic [13:0] off, input logic big);
      ram_fitted = big ? !off[13] : (off[13:11] == RAM_2K_LIMIT);
   endfunction

   always_comb
   begin
      o_prog_mem_oe = !i_addr[15] && !i_local_mem_request_n;
      // The small socket ignores the top line so the 8K part repeats every 8K.
      o_prog_addr = i_prog_16k_jumper ? i_addr[PROG_AW-1:0] : {1'b0, i_addr[PROG_AW-2:0]};
      o_local_shared_request = i_addr[15] && !i_local_mem_request_n && i_local_refresh_cycle_n;
      o_fifo_port = 2'h0;
      if (!i_addr[15])
         o_region = RGN_PROGRAM;
      else if (!i_addr[14])
         o_region = RGN_HWREG;
      else if (i_addr == EVENT_REG_ADDR)
         o_region = RGN_EVENT;
      else if (i_addr == CMD_REG_ADDR)
         o_region = RGN_CMD;
      else if (!ram_fitted(i_addr[13:0], i_ram_8k_jumper) || i_addr > STACK_HI)
         o_region = RGN_UNFITTED;
      else if (i_addr >= STACK_LO)
         o_region = RGN_STACK;
      else if (i_addr >= TX_FIFO_LO)
      begin
         o_region = RGN_TX_FIFO;
         o_fifo_port = 2'((TX_FIFO0_HI - i_addr) >> 4);
      end
      else if (i_addr >= SHARED_CFG_LO)
         o_region = RGN_SHARED_CFG;
      else if (i_addr >= BITMAP_LO)
         o_region = RGN_BITMAP;
      else if (i_addr >= RX_FIFO_LO)
      begin
         o_region = RGN_RX_FIFO;
         o_fifo_port = 2'(RX_PORT0_PAGE - i_addr[10:8]);
      end
      else if (i_addr >= SCRATCH_LO)
         o_region = RGN_SCRATCH;
      else
         o_region = RGN_UNFITTED;
   end

endmodule

// ==== shared_memory_host_decode.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - Match host upper address byte against select code.
// - Strobe enables compare; match drives acknowledge low.
// - Base address is 600000 plus code times 10000.
// - Select code switches default to thirteen.
// - Two switches pick host interrupt level three..six.
// - Interrupt level switches default to level three.
// - Interrupt only while request and gate both set.
// - Console switch reports remote as one, default local.
// - Pack: console, two level bits, five code bits.
// - Low local address half enables program memory.
// - Shared request needs top bit, no refresh.
// - Shared top bit splits RAM from hardware registers.
// - C000 and C001 are event and command registers.
// - Host address is card address doubled plus one.
// - Transmit and receive FIFO areas per port.
// - Bit map, config, scratch and stack areas.
// - Only 2K RAM fitted; jumper selects 8K.
// - Program space 32K; jumper selects 16K part.
// - Three hardware registers, separate read and write decodes.
module shared_memory_host_decode
   import mux_decode_pkg::*;
#(
   parameter logic [4:0] CARD_ID = 5'h0A // Arbitrary value.
)
(
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_backplane_addr_strobe_n,
   input wire host_req_t i_host_req,
   output logic o_card_addressed_ack_n,
   output logic o_host_access_done,
   output logic [7:0] o_host_rdata,
   output logic [3:0] o_host_irq_lines,
   input wire logic i_local_mem_request_n,
   input wire logic i_local_refresh_cycle_n,
   input wire local_req_t i_local_req,
   output logic o_local_wait_n,
   output logic [7:0] o_local_rdata,
   output logic o_prog_mem_oe,
   output logic [PROG_AW-1:0] o_prog_addr,
   output region_t o_local_region,
   output logic [1:0] o_local_fifo_port,
   output logic o_card_cmd_irq,
   output logic o_card_soft_reset,
   input wire logic [7:0] i_switch_pack,
   input wire logic i_ram_8k_jumper,
   input wire logic i_prog_16k_jumper
);

   typedef enum logic [1:0] {ARB_IDLE, ARB_HOST, ARB_CARD} arb_state_t;

   logic [7:0] ram [RAM_DEPTH_MAX];

   logic [7:0] sw_q, sw_d;
   logic cap_q, cap_d;
   arb_state_t st_q, st_d;
   logic last_host_q, last_host_d;
   logic [7:0] event_q, event_d;
   logic [7:0] cmd_q, cmd_d;
   logic irq_req_q, irq_req_d;
   logic cmd_irq_q, cmd_irq_d;
   logic gate_q, gate_d;
   logic sema_q, sema_d;
   logic reset_q, reset_d;
   logic [3:0] lines_q, lines_d;
   logic [7:0] host_rd_q, host_rd_d;
   logic [7:0] card_rd_q, card_rd_d;

   logic match_n;
   logic [3:0] level_sel;
   logic console_remote;
   logic card_req;
   logic host_req;
   logic grant_host;
   logic grant_card;
   logic [SHARED_AW-1:0] sa;
   logic acc_write;
   logic acc_lane_ok;
   logic [7:0] acc_wdata;
   logic in_ram;
   logic is_event;
   logic is_cmd;
   logic fitted;
   logic [12:0] ram_idx;
   logic ram_we;
   logic [7:0] rd_val;
   logic [7:0] ram_rd;

   host_select_decode u_select
   (
      .i_addr_hi(i_host_req.addr[23:16]),
      .i_backplane_addr_strobe_n(i_backplane_addr_strobe_n),
      .i_switch_pack(sw_q),
      .o_select_match_n(match_n),
      .o_level_sel(level_sel),
      .o_console_remote(console_remote)
   );

   local_space_decode u_local
   (
      .i_addr(i_local_req.addr),
      .i_local_mem_request_n(i_local_mem_request_n),
      .i_local_refresh_cycle_n(i_local_refresh_cycle_n),
      .i_ram_8k_jumper(i_ram_8k_jumper),
      .i_prog_16k_jumper(i_prog_16k_jumper),
      .o_prog_mem_oe(o_prog_mem_oe),
      .o_prog_addr(o_prog_addr),
      .o_local_shared_request(card_req),
      .o_region(o_local_region),
      .o_fifo_port(o_local_fifo_port)
   );

   // Arbitration and access steering.
   always_comb
   begin
      host_req = !match_n;
      // Alternate on contention so neither side can starve the other.
      grant_host = (st_q == ARB_IDLE) && host_req && (!card_req || !last_host_q);
      grant_card = (st_q == ARB_IDLE) && card_req && !grant_host;
      st_d = st_q;
      last_host_d = last_host_q;
      case (st_q)
         ARB_IDLE:
         begin
            if (grant_host)
            begin
               st_d = ARB_HOST;
               last_host_d = 1'b1;
            end
            else if (grant_card)
            begin
               st_d = ARB_CARD;
               last_host_d = 1'b0;
            end
         end
         ARB_HOST:
            if (!host_req)
               st_d = ARB_IDLE;
         ARB_CARD:
            if (!card_req)
               st_d = ARB_IDLE;
         default:
            st_d = ARB_IDLE;
      endcase
      // Host byte N of the card sits at host offset 2N+1; even bytes are empty.
      sa = grant_host ? i_host_req.addr[SHARED_AW:1] : i_local_req.addr[SHARED_AW-1:0];
      acc_lane_ok = grant_card || i_host_req.addr[0];
      acc_write = grant_host ? i_host_req.write : i_local_req.write;
      acc_wdata = grant_host ? i_host_req.wdata : i_local_req.wdata;
      in_ram = sa[SHARED_AW-1];
      is_event = in_ram && ({1'b1, sa} == EVENT_REG_ADDR);
      is_cmd = in_ram && ({1'b1, sa} == CMD_REG_ADDR);
      fitted = i_ram_8k_jumper ? !sa[13] : (sa[13:11] == RAM_2K_LIMIT);
      ram_idx = i_ram_8k_jumper ? sa[12:0] : {2'b00, sa[10:0]};
      ram_we = (grant_host || grant_card) && acc_lane_ok && acc_write
         && in_ram && !is_event && !is_cmd && fitted;
   end

   always_ff @(posedge i_clk)
   begin
      if (ram_we)
         ram[ram_idx] <= acc_wdata;
   end

   assign ram_rd = ram[ram_idx];

   // Register group: switches, hardware registers, event and command flags.
   always_comb
   begin
      sw_d = sw_q;
      cap_d = 1'b1;
      if (!cap_q)
         sw_d = i_switch_pack;
      event_d = event_q;
      cmd_d = cmd_q;
      irq_req_d = irq_req_q;
      cmd_irq_d = cmd_irq_q;
      gate_d = gate_q;
      sema_d = sema_q;
      reset_d = reset_q;
      rd_val = OPEN_BUS;
      if ((grant_host || grant_card) && acc_lane_ok)
      begin
         if (!in_ram)
         begin
            case (sa[1:0])
               HWREG_RESET_ID:
                  if (acc_write)
                     reset_d = acc_wdata[CTRL_BIT];
                  else
                     rd_val = {console_remote, 2'b00, CARD_ID};
               HWREG_IRQ:
                  if (acc_write)
                     gate_d = acc_wdata[CTRL_BIT];
                  else
                     rd_val = {gate_q, irq_req_q, sw_q[SW_LEVEL_HI:SW_LEVEL_LO], 4'h0};
               HWREG_SEMA:
               begin
                  // Reading takes the semaphore; any write releases it.
                  sema_d = !acc_write;
                  rd_val = {sema_q, 7'h00};
               end
               default:
                  rd_val = OPEN_BUS;
            endcase
         end
         else if (is_event)
         begin
            rd_val = event_q;
            if (acc_write)
            begin
               event_d = acc_wdata;
               irq_req_d = 1'b1;
            end
            else if (grant_host)
               irq_req_d = 1'b0;
         end
         else if (is_cmd)
         begin
            rd_val = cmd_q;
            if (acc_write)
            begin
               cmd_d = acc_wdata;
               cmd_irq_d = 1'b1;
            end
            else if (grant_card)
               cmd_irq_d = 1'b0;
         end
         else if (fitted)
            rd_val = ram_rd;
      end
      else if (grant_host)
         rd_val = DATA_RESET;
      host_rd_d = (grant_host && !acc_write) ? rd_val : host_rd_q;
      card_rd_d = (grant_card && !acc_write) ? rd_val : card_rd_q;
      lines_d = (irq_req_q && gate_q) ? level_sel : 4'h0;
   end

   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         sw_q <= SWITCH_PACK_RESET;
         cap_q <= 1'b0;
         st_q <= ARB_IDLE;
         last_host_q <= 1'b0;
         event_q <= DATA_RESET;
         cmd_q <= DATA_RESET;
         irq_req_q <= 1'b0;
         cmd_irq_q <= 1'b0;
         gate_q <= 1'b0;
         sema_q <= SEMA_RESET;
         reset_q <= 1'b0;
         lines_q <= 4'h0;
         host_rd_q <= DATA_RESET;
         card_rd_q <= DATA_RESET;
      end
      else
      begin
         sw_q <= sw_d;
         cap_q <= cap_d;
         st_q <= st_d;
         last_host_q <= last_host_d;
         event_q <= event_d;
         cmd_q <= cmd_d;
         irq_req_q <= irq_req_d;
         cmd_irq_q <= cmd_irq_d;
         gate_q <= gate_d;
         sema_q <= sema_d;
         reset_q <= reset_d;
         lines_q <= lines_d;
         host_rd_q <= host_rd_d;
         card_rd_q <= card_rd_d;
      end
   end

   assign o_card_addressed_ack_n = match_n;
   assign o_host_access_done = (st_q == ARB_HOST);
   assign o_host_rdata = host_rd_q;
   assign o_host_irq_lines = lines_q;
   assign o_local_wait_n = !(card_req && (st_q != ARB_CARD));
   assign o_local_rdata = card_rd_q;
   assign o_card_cmd_irq = cmd_irq_q;
   assign o_card_soft_reset = reset_q;

   sequence host_cmd_write;
      grant_host && i_host_req.write && is_cmd && acc_lane_ok;
   endsequence

   sequence card_event_write;
      grant_card && i_local_req.write && is_event;
   endsequence

   a_ack_on_match: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (!i_backplane_addr_strobe_n && i_host_req.addr[23:16] == {3'h3, sw_q[4:0]}) |-> !o_card_addressed_ack_n)
      else $error("select match not acknowledged");

   a_ack_needs_strobe: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      i_backplane_addr_strobe_n |-> o_card_addressed_ack_n)
      else $error("acknowledge without strobe");

   a_base_addr_map: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      !o_card_addressed_ack_n |-> i_host_req.addr[23:16] == SEL_BASE_BYTE + {3'h0, sw_q[4:0]})
      else $error("base address mismatch");

   a_switch_reset_val: assert property (@(posedge i_clk)
      $rose(i_reset_n) |-> (sw_q == 8'h0D && !cap_q))
      else $error("switch default wrong");

   a_irq_line_level: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (irq_req_q && gate_q) |=> o_host_irq_lines == $past(level_sel))
      else $error("wrong interrupt line");

   a_irq_gated_off: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      !(irq_req_q && gate_q) |=> o_host_irq_lines == 4'h0)
      else $error("interrupt while gated");

   a_prog_enable: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      i_local_req.addr[15] |-> !o_prog_mem_oe)
      else $error("program enabled in shared space");

   a_refresh_blocks: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      !i_local_refresh_cycle_n |-> (!card_req && !grant_card))
      else $error("refresh started shared access");

   a_cmd_raises_irq: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      host_cmd_write |=> o_card_cmd_irq)
      else $error("command write gave no card interrupt");

   a_event_raises_req: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      card_event_write |=> irq_req_q ##1 (o_host_irq_lines != 4'h0 || !gate_q))
      else $error("event write gave no host request");

   a_card_stretched: assert property (@(posedge i_clk) disable iff (!i_reset_n)
      (card_req && st_q == ARB_HOST) |-> (!o_local_wait_n && !grant_card))
      else $error("card not stretched during host access");

endmodule

// ==== host_bus_model.sv ====
`timescale 1ns/1ps
module host_bus_model
   import mux_decode_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_ack_n,
   input wire logic i_done,
   input wire logic [7:0] i_rdata,
   output logic o_strobe_n,
   output host_req_t o_req
);
   initial
   begin
      o_strobe_n = 1'b1;
      o_req = '0;
   end

   // The cycle is held whole until done is seen or the limit runs out.
   task automatic access(input logic [23:0] a, input logic w, input logic [7:0] d, input int lim,
                         output logic [7:0] q, output logic ack, output logic fin);
      int n;
      n = 0;
      @(posedge i_clk);
      o_strobe_n <= 1'b0;
      o_req <= '{addr: a, write: w, wdata: d};
      do
      begin
         @(posedge i_clk);
         #1;
         if (n == 0)
            ack = i_ack_n;
         n++;
      end
      while (i_done !== 1'b1 && n < lim);
      q = i_rdata;
      fin = i_done;
      @(posedge i_clk);
      o_strobe_n <= 1'b1;
      // Released lines show the inverse, not a stale copy of the last cycle.
      o_req <= ~o_req;
      repeat (2) @(posedge i_clk);
   endtask
endmodule

// ==== tb_shared_memory_host_decode.sv ====
`timescale 1ns/1ps
module tb_shared_memory_host_decode;
   import mux_decode_pkg::*;
   localparam logic [4:0] ID = 5'h0A; // Arbitrary value.
   localparam logic [15:0] MAP_A[19] = '{16'h0000, 16'h7FFF, 16'h8002, 16'hC000, 16'hC001, 16'hC1FF,
      16'hC200, 16'hC300, 16'hC4FF, 16'hC5FF, 16'hC600, 16'hC76E, 16'hC76F, 16'hC77F, 16'hC78F,
      16'hC79F, 16'hC7AE, 16'hC7AF, 16'hC800};
   localparam region_t MAP_R[19] = '{RGN_PROGRAM, RGN_PROGRAM, RGN_HWREG, RGN_EVENT, RGN_CMD,
      RGN_SCRATCH, RGN_RX_FIFO, RGN_RX_FIFO, RGN_RX_FIFO, RGN_RX_FIFO, RGN_BITMAP, RGN_SHARED_CFG,
      RGN_TX_FIFO, RGN_TX_FIFO, RGN_TX_FIFO, RGN_TX_FIFO, RGN_TX_FIFO, RGN_STACK, RGN_UNFITTED};
   localparam logic [1:0] MAP_P[19] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h3, 2'h2, 2'h1, 2'h0,
      2'h0, 2'h0, 2'h3, 2'h2, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0};
   localparam logic [4:0] CODES[4] = '{5'h0D, 5'h00, 5'h1F, 5'h13};
   logic i_clk, i_reset_n, strobe_n, ack_n, done, wait_n, prog_oe, cmd_irq, soft_rst, ram8k, prog16k;
   logic mreq_n, rfsh_n, k, f;
   host_req_t hreq;
   local_req_t lreq;
   logic [7:0] hrdata, rdata_l, sw, q, r;
   logic [3:0] irq;
   logic [13:0] prog_addr;
   region_t region;
   logic [1:0] fport;
   logic [23:0] hb;
   int num_errors = 0;
   int n_checks = 0;

   shared_memory_host_decode #(.CARD_ID(ID)) dut (.i_clk(i_clk), .i_reset_n(i_reset_n),
      .i_backplane_addr_strobe_n(strobe_n), .i_host_req(hreq), .o_card_addressed_ack_n(ack_n),
      .o_host_access_done(done), .o_host_rdata(hrdata), .o_host_irq_lines(irq),
      .i_local_mem_request_n(mreq_n), .i_local_refresh_cycle_n(rfsh_n), .i_local_req(lreq),
      .o_local_wait_n(wait_n), .o_local_rdata(rdata_l), .o_prog_mem_oe(prog_oe), .o_prog_addr(prog_addr),
      .o_local_region(region), .o_local_fifo_port(fport), .o_card_cmd_irq(cmd_irq),
      .o_card_soft_reset(soft_rst), .i_switch_pack(sw), .i_ram_8k_jumper(ram8k), .i_prog_16k_jumper(prog16k));

   host_bus_model u_host (.i_clk(i_clk), .i_ack_n(ack_n), .i_done(done), .i_rdata(hrdata),
      .o_strobe_n(strobe_n), .o_req(hreq));

   initial
   begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("Checks %0d, errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   function automatic logic [23:0] hoff(input logic [15:0] a);
      return {hb[23:16], a[14:0], 1'b1};
   endfunction

   task automatic settle(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask

   task automatic do_reset(input logic [7:0] s);
      @(posedge i_clk);
      i_reset_n <= 1'b0;
      sw <= s;
      repeat (2) @(posedge i_clk);
      i_reset_n <= 1'b1;
      repeat (2) @(posedge i_clk);
   endtask

   task automatic host(input logic [15:0] a, input logic w, input logic [7:0] d);
      logic ak, fn;
      u_host.access(hoff(a), w, d, 50, q, ak, fn);
      check(16'({ak, fn}), 16'h0001);
   endtask

   task automatic card(input logic [15:0] a, input logic w, input logic [7:0] d, output logic [7:0] v);
      int n;
      n = 0;
      @(posedge i_clk);
      mreq_n <= 1'b0;
      lreq <= '{addr: a, write: w, wdata: d};
      do
      begin
         @(posedge i_clk);
         #1;
         n++;
      end
      while (wait_n !== 1'b1 && n < 50);
      v = rdata_l;
      check(16'(wait_n), 16'h0001);
      @(posedge i_clk);
      mreq_n <= 1'b1;
      lreq <= ~lreq;
      @(posedge i_clk);
   endtask

   initial
   begin
      // Long enough for every scenario with a wide margin; a hang is cut here.
      #100000;
      num_errors++;
      complete_run();
   end

   initial
   begin
      i_reset_n = 1'b0;
      sw = 8'h0D;
      mreq_n = 1'b1;
      rfsh_n = 1'b1;
      lreq = '0;
      ram8k = 1'b0;
      prog16k = 1'b0;
      hb = 24'h6D0000;
      for (int lv = 0; lv < 4; lv++)
      begin
         logic [1:0] l;
         l = lv[1:0];
         do_reset({l[0], l, CODES[lv]});
         hb = 24'h600000 + {3'h0, CODES[lv], 16'h0000};
         u_host.access({hb[23:16] ^ 8'h01, 16'h0001}, 1'b0, 8'h00, 3, q, k, f);
         check(16'(k), 16'h0001);
         u_host.access({hb[23:16] ^ 8'h80, 16'h0001}, 1'b0, 8'h00, 3, q, k, f);
         check(16'(k), 16'h0001);
         host(16'h8000, 1'b0, 8'h00);
         check(16'(q), 16'({l[0], 2'b00, ID}));
         card(16'hC000, 1'b1, 8'h00, r);
         settle(2);
         check(16'(irq), 16'h0000);
         host(16'h8001, 1'b1, 8'h80);
         settle(2);
         check(16'(irq), 16'(4'h1 << l));
         host(16'h8001, 1'b0, 8'h00);
         check(16'(q), 16'({2'b11, l, 4'h0}));
         host(16'hC000, 1'b0, 8'h00);
         settle(2);
         check(16'(irq), 16'h0000);
      end
      host(16'h8002, 1'b0, 8'h00);
      check(16'(q), 16'h0080);
      card(16'h8002, 1'b0, 8'h00, r);
      check(16'(r), 16'h0080);
      host(16'h8002, 1'b1, 8'h00);
      card(16'h8002, 1'b0, 8'h00, r);
      check(16'(r), 16'h0000);
      // Only three registers exist, so the fourth slot must read as an open bus.
      host(16'h8003, 1'b0, 8'h00);
      check(16'(q), 16'h00FF);
      card(16'h8003, 1'b0, 8'h00, r);
      check(16'(r), 16'h00FF);
      host(16'h8000, 1'b1, 8'h80);
      settle(1);
      check(16'(soft_rst), 16'h0001);
      host(16'h8000, 1'b1, 8'h00);
      settle(1);
      check(16'(soft_rst), 16'h0000);
      host(16'hC001, 1'b1, 8'h5A);
      settle(1);
      check(16'(cmd_irq), 16'h0001);
      card(16'hC001, 1'b0, 8'h00, r);
      check(16'(r), 16'h005A);
      settle(1);
      check(16'(cmd_irq), 16'h0000);
      host(16'hC123, 1'b1, 8'hA5);
      card(16'hC123, 1'b0, 8'h00, r);
      check(16'(r), 16'h00A5);
      u_host.access(hoff(16'hC123) ^ 24'h000001, 1'b0, 8'h00, 50, q, k, f);
      check(16'(q), 16'h0000);
      card(16'hC7FF, 1'b1, 8'h3C, r);
      host(16'hC7FF, 1'b0, 8'h00);
      check(16'(q), 16'h003C);
      card(16'hC800, 1'b0, 8'h00, r);
      check(16'(r), 16'h00FF);
      ram8k <= 1'b1;
      card(16'hC900, 1'b1, 8'h11, r);
      card(16'hC900, 1'b0, 8'h00, r);
      check(16'(r), 16'h0011);
      ram8k <= 1'b0;
      fork
         host(16'hC200, 1'b1, 8'h77);
         card(16'hC201, 1'b1, 8'h66, r);
      join
      host(16'hC201, 1'b0, 8'h00);
      check(16'(q), 16'h0066);
      card(16'hC200, 1'b0, 8'h00, r);
      check(16'(r), 16'h0077);
      // Refresh cycles walk the whole map; none of them may open a shared access.
      @(posedge i_clk);
      mreq_n <= 1'b0;
      rfsh_n <= 1'b0;
      lreq.write <= 1'b1;
      for (int i = 0; i < 19; i++)
      begin
         @(posedge i_clk);
         lreq.addr <= MAP_A[i];
         #1;
         check(16'(region), 16'(MAP_R[i]));
         check(16'(fport), 16'(MAP_P[i]));
         check(16'({prog_oe, wait_n}), 16'({~MAP_A[i][15], 1'b1}));
         check(16'(prog_addr), 16'(MAP_A[i][12:0]));
      end
      @(posedge i_clk);
      lreq.addr <= 16'h7FFF;
      prog16k <= 1'b1;
      #1;
      check(16'(prog_addr), 16'h3FFF);
      @(posedge i_clk);
      mreq_n <= 1'b1;
      rfsh_n <= 1'b1;
      prog16k <= 1'b0;
      host(16'h8001, 1'b0, 8'h00);
      check(16'(q & 8'h40), 16'h0000);
      complete_run();
   end
endmodule
